// *** core/adcc_ctrl.sv ***
// Control and sequencing for a 10-bit successive-approximation converter.
// Assumes synchronous inputs, an analog core that answers i_cmp each
// conversion clock period, and a plain register port.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int DIV_W = 6
)
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [1:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_sleep,
  input  wire logic        i_irq_enable,
  input  wire logic        i_flag_clear,
  input  wire logic        i_frc_tick,
  input  wire logic        i_instr_tick,
  input  wire logic        i_cmp,
  output logic             o_powered,
  output logic             o_acquire,
  output logic      [2:0]  o_channel,
  output logic             o_ref_ext,
  output logic      [9:0]  o_dac_code,
  output logic             o_done_flag,
  output logic             o_wake,
  output logic             o_busy
);

  logic             ctl_en;
  logic             ctl_fmt;
  logic             ctl_ref;
  logic [2:0]       ctl_chs;
  logic [2:0]       clk_sel;
  logic [7:0]       res_h;
  logic [7:0]       res_l;
  adcc_state_t      state;
  adcc_state_t      next_state;
  logic [3:0]       tad_cnt;
  logic [3:0]       next_tad;
  logic [9:0]       sar;
  logic [9:0]       mask;
  logic [DIV_W-1:0] div_cnt;
  logic             pdown;

  // Register port decode.
  wire wr_ctl = i_wr & (i_addr == `AC_OFS_CTL);
  wire wr_clk = i_wr & (i_addr == `AC_OFS_CLK);
  wire wr_rh  = i_wr & (i_addr == `AC_OFS_RH);
  wire wr_rl  = i_wr & (i_addr == `AC_OFS_RL);
  wire w_go   = i_wdata[`AC_GO_BIT];
  wire w_en   = i_wdata[`AC_EN_BIT];

  // Status and clock source decode.
  wire busy   = (state == ST_WAIT) | (state == ST_CONV);
  wire is_frc = clk_sel[1:0] == `AC_FRC_CODE;

  // Divide by two to the power one plus two times the low bits plus
  // the high bit: codes give 2, 4, 8, 16, 32 and 64.
  wire [2:0] div_exp = `AC_DIV_BASE + {clk_sel[1:0], 1'b0}
                       + {2'h0, clk_sel[2]};
  wire [DIV_W:0] div_full = ({{DIV_W{1'b0}}, 1'b1} << div_exp);
  wire [DIV_W-1:0] div_top = div_full[DIV_W-1:0] - 1'b1;
  wire div_tick = div_cnt == div_top;
  wire tad_tick = is_frc ? i_frc_tick : div_tick;

  // Conversion events. A start needs the enable from an earlier write,
  // so a write that both enables and starts only enables; a software
  // abort differs from a kill in that it keeps the two-period gap.
  wire sleep_blk   = i_sleep & ~is_frc;
  wire start       = wr_ctl & w_go & w_en & ctl_en & ~busy
                     & (state != ST_ABORT) & ~sleep_blk;
  wire sleep_abort = busy & sleep_blk;
  wire kill        = sleep_abort | (wr_ctl & ~w_en & busy);
  wire sw_abort    = wr_ctl & ~w_go & busy;
  wire complete    = (state == ST_CONV) & tad_tick
                     & (tad_cnt == `AC_LAST_TAD);
  wire abort_end   = (state == ST_ABORT) & tad_tick
                     & (tad_cnt == `AC_ABORT_LAST);

  // Next trial value: keep or drop the bit under test, try the next.
  wire [9:0] next_sar = (i_cmp ? sar : (sar & ~mask)) | (mask >> 1);

  // Result bytes in the selected justification.
  wire [7:0] fmt_h = ctl_fmt ? {6'h00, next_sar[9:8]}
                             : next_sar[9:2];
  wire [7:0] fmt_l = ctl_fmt ? next_sar[7:0]
                             : {next_sar[1:0], 6'h00};

  // Read data selection; unimplemented bits read as zero.
  wire [7:0] ctl_rd = {ctl_fmt, ctl_ref, 1'b0, ctl_chs, busy,
                       ctl_en};
  wire [7:0] clk_rd = {1'b0, clk_sel, 4'h0};
  wire [7:0] rd_mux = (i_addr == `AC_OFS_CTL) ? ctl_rd :
                      (i_addr == `AC_OFS_CLK) ? clk_rd :
                      (i_addr == `AC_OFS_RH)  ? res_h  : res_l;

  // Power-down in Sleep after a Sleep abort or a completion with interrupts off, released when Sleep falls.
  // Release on the fall of Sleep means no register bit has to change.
  wire pd_set = sleep_abort
                | (complete & i_sleep & ~i_irq_enable);
  wire next_pd = i_sleep & (pdown | pd_set);

  // Sequencer next state.
  // A kill beats an abort, and both beat the normal flow.
  always_comb
  begin
    next_state = state;
    if (kill)
      next_state = ST_IDLE;
    else if (sw_abort)
      next_state = ST_ABORT;
    else
      unique case (state)
        ST_IDLE:
          if (start)
            next_state = is_frc ? ST_WAIT : ST_CONV;
        ST_WAIT:
          if (i_instr_tick)
            next_state = ST_CONV;
        ST_CONV:
          if (complete)
            next_state = ST_IDLE;
        ST_ABORT:
          if (abort_end)
            next_state = ST_IDLE;
      endcase
  end

  // Period counter restarts on every state change.
  always_comb
  begin
    if (next_state != state)
      next_tad = 4'h0;
    else if (tad_tick)
      next_tad = tad_cnt + 4'h1;
    else
      next_tad = tad_cnt;
  end

  // Sequencer and period counters.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state   <= ST_IDLE;
      tad_cnt <= 4'h0;
      div_cnt <= '0;
      pdown   <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      tad_cnt <= next_tad;
      div_cnt <= (next_state != state || div_tick) ? '0
                 : div_cnt + 1'b1;
      pdown   <= next_pd;
    end
  end

  // Successive approximation: first period sets the top trial bit,
  // each later period resolves one bit from the core's comparator.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sar  <= 10'h000;
      mask <= 10'h000;
    end
    else if (state != ST_CONV)
    begin
      sar  <= 10'h000;
      mask <= `AC_SAR_MSB;
    end
    else if (tad_tick && tad_cnt == 4'h0)
      sar <= mask;
    else if (tad_tick)
    begin
      sar  <= next_sar;
      mask <= mask >> 1;
    end
  end

  // Control registers.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctl_en  <= 1'b0;
      ctl_fmt <= 1'b0;
      ctl_ref <= 1'b0;
      ctl_chs <= 3'h0;
      clk_sel <= `AC_CLK_RST;
    end
    else
    begin
      if (wr_ctl)
      begin
        ctl_en  <= w_en;
        ctl_fmt <= i_wdata[`AC_FMT_BIT];
        ctl_ref <= i_wdata[`AC_REF_BIT];
        ctl_chs <= i_wdata[`AC_CHS_MSB:`AC_CHS_LSB];
      end
      if (wr_clk)
        clk_sel <= i_wdata[`AC_CS_MSB:`AC_CS_LSB];
    end
  end

  // Result pair: both bytes load together; completion beats a write.
  // A write losing to completion keeps the pair from mixing two results.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      res_h <= 8'h00;
      res_l <= 8'h00;
    end
    else if (complete)
    begin
      res_h <= fmt_h;
      res_l <= fmt_l;
    end
    else
    begin
      if (wr_rh)
        res_h <= i_wdata;
      if (wr_rl)
        res_l <= i_wdata;
    end
  end

  // Done flag, wake pulse and read data.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_done_flag <= 1'b0;
      o_wake      <= 1'b0;
      o_rdata     <= 8'h00;
    end
    else
    begin
      o_done_flag <= complete | (o_done_flag & ~i_flag_clear);
      o_wake      <= complete & i_sleep & i_irq_enable;
      o_rdata     <= i_rd ? rd_mux : o_rdata;
    end
  end

  // Converter-facing controls.
  assign o_powered  = ctl_en & ~pdown;
  assign o_acquire  = o_powered & (state == ST_IDLE);
  assign o_channel  = ctl_chs;
  assign o_ref_ext  = ctl_ref;
  assign o_dac_code = sar;
  assign o_busy     = busy;

  // Checks on the sequencing.
  // They watch only what this block drives.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Helper count of periods spent converting, kept apart from the
  // sequencer's own counter so the eleven-period check is independent.
  logic [3:0] conv_ticks;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      conv_ticks <= 4'h0;
    else if (state != ST_CONV)
      conv_ticks <= 4'h0;
    else if (tad_tick)
      conv_ticks <= conv_ticks + 4'h1;
  end

  AST_DONE_SEQ: assert property (
    complete && !kill |=> !o_busy && o_done_flag)
    else $error("Completion did not clear status or set flag.");

  AST_ELEVEN: assert property (
    complete |-> conv_ticks == `AC_LAST_TAD)
    else $error("Conversion did not last eleven periods.");

  AST_RESULT_HOLD: assert property (
    (res_h != $past(res_h) || res_l != $past(res_l))
      |-> $past(complete || wr_rh || wr_rl))
    else $error("Result changed without completion or write.");

  AST_ABORT_GAP: assert property (
    sw_abort && !kill |=> !o_acquire [*2])
    else $error("Acquisition resumed too soon after abort.");

  AST_OFF: assert property (
    !ctl_en |-> !o_powered && !o_acquire)
    else $error("Disabled converter still powered.");

  AST_STATUS: assert property (
    i_rd && i_addr == `AC_OFS_CTL |=> o_rdata[1] == $past(busy))
    else $error("Status bit read back wrong.");

  AST_UNIMPL: assert property (
    i_rd && i_addr == `AC_OFS_CLK |=> o_rdata[7] == 1'b0
      && o_rdata[3:0] == 4'h0)
    else $error("Unimplemented bits read nonzero.");

  AST_SLEEP_KILL: assert property (
    sleep_abort |=> !o_busy && !o_powered)
    else $error("Sleep did not abort conversion.");

  AST_FRC_WAIT: assert property (
    start && is_frc |=> state == ST_WAIT)
    else $error("Internal oscillator start not delayed.");

  AST_WAKE: assert property (
    complete && i_sleep && i_irq_enable |=> o_wake ##1 !o_wake)
    else $error("Wake pulse missing or too long.");

  // Further checks on start, flag, abort gap, Sleep power-down and result padding.
  // Each one guards a path that a single scenario could miss.
  AST_START_BUSY: assert property (
    start |=> o_busy)
    else $error("Start write did not begin a conversion.");

  AST_NO_START_OFF: assert property (
    wr_ctl && !ctl_en |=> !o_busy)
    else $error("Conversion began while converter was disabled.");

  AST_FLAG_STICKY: assert property (
    o_done_flag && !i_flag_clear |=> o_done_flag)
    else $error("Done flag cleared without software clear.");

  AST_ABORT_END: assert property (
    abort_end |=> o_acquire == o_powered)
    else $error("Acquisition did not resume after abort delay.");

  AST_PD_HOLD: assert property (
    complete && i_sleep && !i_irq_enable |=> !o_powered)
    else $error("Converter stayed powered after Sleep completion.");

  AST_RIGHT_PAD: assert property (
    complete && ctl_fmt |=> res_h[7:2] == 6'h00)
    else $error("Right-justified high byte has upper bits set.");

  AST_LEFT_PAD: assert property (
    complete && !ctl_fmt |=> res_l[5:0] == 6'h00)
    else $error("Left-justified low byte has lower bits set.");

endmodule : adcc_ctrl
`default_nettype wire

// *** inc/adcc_defs.svh ***
// Constants for the converter control block: offsets, fields, counts.
// Assumes inclusion by bare name from the include path.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define AC_OFS_CTL 2'h0
`define AC_OFS_CLK 2'h1
`define AC_OFS_RH 2'h2
`define AC_OFS_RL 2'h3
`define AC_CTL_RST 8'h00
`define AC_CLK_RST 3'h0
`define AC_EN_BIT 0
`define AC_GO_BIT 1
`define AC_CHS_MSB 4
`define AC_CHS_LSB 2
`define AC_REF_BIT 6
`define AC_FMT_BIT 7
`define AC_CS_MSB 6
`define AC_CS_LSB 4
`define AC_FRC_CODE 2'h3
`define AC_LAST_TAD 4'hA
`define AC_ABORT_LAST 4'h1
`define AC_SAR_MSB 10'h200
`define AC_DIV_BASE 3'h1
`endif

// *** inc/adcc_pkg.sv ***
// Types shared by the converter control block.
// Assumes nothing of its surroundings.
package adcc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV, ST_ABORT}
    adcc_state_t;
endpackage : adcc_pkg

// *** verif/adcc_core_model.sv ***
// Behavioural model of the comparator core; the channel multiplexer is not modelled.
// Assumes the trial code is driven by the control block each clock.
`timescale 1ns/100ps
`default_nettype none

module adcc_core_model
(
  input  wire logic       i_clk,
  input  wire logic [9:0] i_vin,
  input  wire logic [9:0] i_code,
  input  wire logic       i_powered,
  output logic            o_cmp
);
  logic junk = 1'b0;

  // An unpowered core gives no valid answer, so the output wanders.
  always @(posedge i_clk)
    junk <= ~junk;

  // Comparator keeps the trial bit when the input reaches the code.
  assign o_cmp = i_powered ? (i_vin >= i_code) : junk;
endmodule : adcc_core_model

`default_nettype wire

// *** verif/adcc_ctrl_tb.sv ***
// Self-checking testbench for the converter control block.
// Assumes the design, its package and the core model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module adcc_ctrl_tb;
  import adcc_pkg::*;
  typedef struct {logic [2:0] cs; logic [7:0] ctl; logic [9:0] vin;}
    adcc_row_t;
  logic       clk, rst_n, wr, rd, slp, irq_en, fclr, cmp;
  logic       frc = 1'b0;
  logic       itk = 1'b0;
  logic [1:0] addr;
  logic [7:0] wd, rdata;
  logic [9:0] vin, code;
  logic       pwr, acq, ref_ext, flag, wake, busy;
  logic [2:0] chan;
  logic [3:0] tcnt = 4'h0;
  logic [15:0] exp_res;
  int         n_fail = 0, compares = 0, wakes = 0, n;
  adcc_row_t  rows[8] = '{'{3'h0, 8'h80, 10'h3FF}, '{3'h4, 8'h00, 10'h001},
    '{3'h1, 8'hC4, 10'h2A5}, '{3'h5, 8'h48, 10'h155},
    '{3'h2, 8'h8C, 10'h200}, '{3'h6, 8'h10, 10'h1FF},
    '{3'h3, 8'hD4, 10'h000}, '{3'h7, 8'h18, 10'h3C3}};

  adcc_ctrl #(.DIV_W(6)) u_dut (.i_clk(clk), .i_arst_n(rst_n),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_sleep(slp), .i_irq_enable(irq_en), .i_flag_clear(fclr),
    .i_frc_tick(frc), .i_instr_tick(itk), .i_cmp(cmp), .o_powered(pwr),
    .o_acquire(acq), .o_channel(chan), .o_ref_ext(ref_ext),
    .o_dac_code(code), .o_done_flag(flag), .o_wake(wake), .o_busy(busy));

  adcc_core_model u_core (.i_clk(clk), .i_vin(vin), .i_code(code),
    .i_powered(pwr), .o_cmp(cmp));

  // Clock of 10 ns period.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Tick sources for the internal oscillator and instructions; wake count.
  always @(posedge clk)
  begin
    tcnt <= tcnt + 4'h1;
    frc <= (tcnt[2:0] == 3'h6);
    itk <= (tcnt[1:0] == 2'h1);
    if (wake === 1'b1)
      wakes <= wakes + 1;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wrreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrreg

  task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rdchk

  // Counts the clocks for which a conversion stays in progress.
  task automatic waitdone();
    n = 0;
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(busy, 1'b0);
  endtask : waitdone

  task automatic clrflag();
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    #1;
    chk(flag, 1'b0);
  endtask : clrflag

  function automatic int divof(input logic [2:0] cs);
    case (cs)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return 0;
    endcase
  endfunction : divof

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Bounds the run in case a handshake never arrives.
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end

  // Main sequence: reset, register table, conversions, awkward cases.
  initial
  begin
    rst_n = 1'b0;
    addr = 2'h0;
    wd = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    slp = 1'b0;
    irq_en = 1'b0;
    fclr = 1'b0;
    vin = 10'h000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(2'h0, 8'h00);
    rdchk(2'h1, 8'h00);
    wrreg(2'h1, 8'hFF);
    rdchk(2'h1, 8'h70);
    wrreg(2'h0, 8'hFC);
    chk(pwr, 1'b0);
    rdchk(2'h0, 8'hDC);
    foreach (rows[i])
    begin
      vin <= rows[i].vin;
      exp_res = rows[i].ctl[7] ? {6'h00, rows[i].vin} :
                {rows[i].vin, 6'h00};
      wrreg(2'h1, {1'b0, rows[i].cs, 4'h0});
      wrreg(2'h0, rows[i].ctl | 8'h01);
      chk(chan, rows[i].ctl[4:2]);
      chk(ref_ext, rows[i].ctl[6]);
      chk({pwr, acq}, 2'h3);
      repeat (4) @(posedge clk);
      wrreg(2'h0, rows[i].ctl | 8'h03);
      chk(busy, 1'b1);
      waitdone();
      if (divof(rows[i].cs) != 0)
        chk(n, 16'(11 * divof(rows[i].cs)));
      chk(flag, 1'b1);
      rdchk(2'h0, rows[i].ctl | 8'h01);
      rdchk(2'h2, exp_res[15:8]);
      rdchk(2'h3, exp_res[7:0]);
      clrflag();
    end
    wrreg(2'h1, 8'h00);
    wrreg(2'h0, 8'h1D);
    vin <= 10'h0F0;
    wrreg(2'h0, 8'h1F);
    repeat (6) @(posedge clk);
    wrreg(2'h0, 8'h1D);
    chk({busy, acq, flag}, 3'h0);
    repeat (3) @(posedge clk);
    #1;
    chk(acq, 1'b0);
    repeat (1) @(posedge clk);
    #1;
    chk(acq, 1'b1);
    rdchk(2'h2, exp_res[15:8]);
    rdchk(2'h3, exp_res[7:0]);
    wrreg(2'h0, 8'h00);
    wrreg(2'h0, 8'h03);
    chk(busy, 1'b0);
    wrreg(2'h0, 8'h03);
    slp <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({busy, pwr}, 2'h0);
    rdchk(2'h0, 8'h01);
    slp <= 1'b0;
    wrreg(2'h1, 8'h30);
    irq_en <= 1'b1;
    wrreg(2'h0, 8'h03);
    slp <= 1'b1;
    waitdone();
    chk({flag, wake}, 2'h3);
    irq_en <= 1'b0;
    clrflag();
    wrreg(2'h0, 8'h03);
    waitdone();
    chk({pwr, wakes[1:0]}, 3'h1);
    rdchk(2'h0, 8'h01);
    slp <= 1'b0;
    wrreg(2'h0, 8'h03);
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({busy, pwr}, 2'h0);
    rst_n <= 1'b1;
    rdchk(2'h0, 8'h00);
    wrap_up();
  end
endmodule : adcc_ctrl_tb

`default_nettype wire
